// *** fsr_regbank.sv ***
// Floppy status registers and drive output control register
// How it works
// RULE1: Eight offsets decoded; offset 6 reserved; nothing else answered.
// RULE2: Legacy mode leaves data bus undriven on status A and B reads.
// RULE3: Full-status mode reads both status registers at any time.
// RULE4: Full-status A: dir, wp_n, index_n, side, trk0_n, step, drv2_n, irq.
// RULE5: Compact A: inverted dir/side, active-high pins, step latch, drq, irq.
// RULE6: Compact step latch sets on step rising, clears on input read or reset.
// RULE7: Full-status B bits 0-2 show motors 0,1 and write gate.
// RULE8: Those motor bits clear on hardware reset only.
// RULE9: Full-status B bits 3,4 toggle on read/write data falling edges.
// RULE10: Full-status B bit 5 mirrors drive select bit 0.
// RULE11: Full-status B bits 6 and 7 read one.
// RULE12: Compact B: ds2_n, ds3_n, write_gate/rdata/wdata latches, ds0_n, ds1_n, drv2_n.
// RULE13: Compact B resets with selects high, latches low, bit7 live; code resets ds0_n low, since drive select 0 decodes at reset.
// RULE14: Write-gate latch sets on rising edge, clears on input read.
// RULE15: Data latches set on falling edges, clear on input read, ungated.
// RULE16: Output control holds motors, dma gate, soft reset, select; resets zero.
// RULE17: Drive select decodes to one-hot selects.
// RULE18: Soft reset bit low holds controller reset; register itself unaffected.
// RULE19: Soft reset of at least 100ns; back-to-back writes suffice.
// RULE20: Legacy/compact dma gate enables drq/irq pins and dack/tc inputs.
// RULE21: Full-status mode keeps dma and irq pins always enabled.
// RULE22: Each motor bit drives its motor output active.
// RULE23: Mode is a static input choosing status layout.
// RULE24: Drive inputs synchronised before edge detection.
`timescale 1ns/10ps
`include "fsr_regs.svh"
module fsr_regbank
  import fsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire fsr_mode_e mode,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_data_oe,
  output logic rd_hit,
  input wire fsr_drive_s drive_in,
  input wire logic irq_core,
  input wire logic drq_core,
  input wire logic dack_n,
  input wire logic tc,
  output logic floppy_irq_out,
  output logic floppy_irq_oe,
  output logic drq_out,
  output logic drq_oe,
  output logic dack_n_core,
  output logic tc_core,
  output logic [3:0] motor_on,
  output logic [3:0] drive_sel,
  output logic ctrl_reset_n,
  output logic main_rd,
  output logic data_rd,
  output logic data_wr,
  output logic tape_wr,
  output logic rate_wr,
  output logic cfg_wr
);
  fsr_doc_s doc_ff;
  fsr_drive_s sync1_ff;
  fsr_drive_s sync2_ff;
  fsr_drive_s prev_ff;
  logic step_latch_ff;
  logic write_gate_latch_ff;
  logic rdata_latch_ff;
  logic wdata_latch_ff;
  logic rdata_tog_ff;
  logic wdata_tog_ff;
  logic [7:0] rd_data_ff;
  logic rd_oe_ff;
  logic rd_hit_ff;
  logic [3:0] sel_onehot;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic [7:0] nxt_rd_data;
  logic nxt_rd_oe;
  logic din_rd;
  logic step_rise;
  logic write_gate_rise;
  logic rdata_fall;
  logic wdata_fall;
  logic dma_on;
  logic [3:0] srst_cnt_ff;

  // Two-stage synchroniser on drive pins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      sync1_ff <= drive_in; // [RULE24]
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Edges from synchronised samples
  assign step_rise = sync2_ff.step && !prev_ff.step; // [RULE24]
  assign write_gate_rise = sync2_ff.write_gate && !prev_ff.write_gate;
  assign rdata_fall = !sync2_ff.read_data && prev_ff.read_data;
  assign wdata_fall = !sync2_ff.write_data && prev_ff.write_data;

  assign din_rd = rd_stb && (addr == `FSR_OFS_DIN);

  // Output control register, hardware reset only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      doc_ff <= `FSR_DOC_RESET; // [RULE16] [RULE8] [RULE10]
    else if (wr_stb && addr == `FSR_OFS_DOC)
      doc_ff <= wr_data; // [RULE16] [RULE19]
  end

  // Soft reset stretch; a one-cycle low pulse still meets the minimum width
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      srst_cnt_ff <= 4'(`FSR_SRST_CYC);
    else if (!doc_ff.soft_reset_n)
      srst_cnt_ff <= 4'(`FSR_SRST_CYC); // [RULE19]
    else if (srst_cnt_ff != 4'h0)
      srst_cnt_ff <= srst_cnt_ff - 4'h1; // [RULE19]
  end

  // Core held in reset while bit low and during the stretch
  assign ctrl_reset_n = doc_ff.soft_reset_n && (srst_cnt_ff == 4'h0); // [RULE18] [RULE19]

  // Latches cleared by input-register read or hardware reset, step latch also by soft reset; set wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      step_latch_ff <= 1'b0;
      write_gate_latch_ff <= 1'b0;
      rdata_latch_ff <= 1'b0;
      wdata_latch_ff <= 1'b0;
    end
    else
    begin
      if (step_rise)
        step_latch_ff <= 1'b1; // [RULE6]
      else if (din_rd || !doc_ff.soft_reset_n)
        step_latch_ff <= 1'b0; // [RULE6]
      if (write_gate_rise)
        write_gate_latch_ff <= 1'b1; // [RULE14]
      else if (din_rd)
        write_gate_latch_ff <= 1'b0; // [RULE14]
      if (rdata_fall)
        rdata_latch_ff <= 1'b1; // [RULE15]
      else if (din_rd)
        rdata_latch_ff <= 1'b0; // [RULE15]
      if (wdata_fall)
        wdata_latch_ff <= 1'b1; // [RULE15]
      else if (din_rd)
        wdata_latch_ff <= 1'b0; // [RULE15]
    end
  end

  // Data toggle bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_tog_ff <= 1'b0;
      wdata_tog_ff <= 1'b0;
    end
    else
    begin
      if (rdata_fall)
        rdata_tog_ff <= !rdata_tog_ff; // [RULE9]
      if (wdata_fall)
        wdata_tog_ff <= !wdata_tog_ff; // [RULE9]
    end
  end

  // One-hot drive select decode
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sel
      assign sel_onehot[gi] = (doc_ff.drive_sel == gi[1:0]); // [RULE17]
    end
  endgenerate

  assign drive_sel = sel_onehot;
  assign motor_on = doc_ff.motor_en; // [RULE22]

  // DMA and interrupt pin gating
  assign dma_on = (mode == FSR_MODE_FULL) || doc_ff.dma_gate; // [RULE20] [RULE21]
  assign floppy_irq_out = irq_core;
  assign floppy_irq_oe = dma_on; // [RULE20] [RULE21]
  assign drq_out = drq_core;
  assign drq_oe = dma_on; // [RULE20] [RULE21]
  assign dack_n_core = dma_on ? dack_n : 1'b1; // [RULE20]
  assign tc_core = dma_on ? tc : 1'b0; // [RULE20]

  // Status register layouts by mode
  always_comb
  begin
    if (mode == FSR_MODE_COMPACT)
    begin
      stat_a = {irq_core, drq_core, step_latch_ff, !sync2_ff.track_zero_n,
                !sync2_ff.head_side, !sync2_ff.index_pulse_n,
                !sync2_ff.write_protect_n, !sync2_ff.direction_in}; // [RULE5]
      stat_b = {sync2_ff.second_drive_present_n, !sel_onehot[1], !sel_onehot[0],
                wdata_latch_ff, rdata_latch_ff, write_gate_latch_ff,
                !sel_onehot[3], !sel_onehot[2]}; // [RULE12] [RULE13]
    end
    else
    begin
      stat_a = {irq_core, sync2_ff.second_drive_present_n, sync2_ff.step,
                sync2_ff.track_zero_n, sync2_ff.head_side, sync2_ff.index_pulse_n,
                sync2_ff.write_protect_n, sync2_ff.direction_in}; // [RULE4]
      stat_b = {2'b11, doc_ff.drive_sel[0], wdata_tog_ff, rdata_tog_ff,
                sync2_ff.write_gate, doc_ff.motor_en[1:0]}; // [RULE7] [RULE10] [RULE11]
    end
  end

  // Read decode; status offsets float in legacy mode
  always_comb
  begin
    nxt_rd_data = 8'h00;
    nxt_rd_oe = 1'b0;
    case (addr)
      `FSR_OFS_STAT_A:
      begin
        nxt_rd_data = stat_a; // [RULE3]
        nxt_rd_oe = (mode != FSR_MODE_LEGACY); // [RULE2]
      end
      `FSR_OFS_STAT_B:
      begin
        nxt_rd_data = stat_b; // [RULE3]
        nxt_rd_oe = (mode != FSR_MODE_LEGACY); // [RULE2]
      end
      `FSR_OFS_DOC:
      begin
        nxt_rd_data = doc_ff;
        nxt_rd_oe = 1'b1;
      end
      `FSR_OFS_RSVD:
      begin
        nxt_rd_data = 8'h00; // [RULE1]
        nxt_rd_oe = 1'b0;
      end
      default:
      begin
        nxt_rd_data = 8'h00;
        nxt_rd_oe = 1'b0;
      end
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_ff <= 8'h00;
      rd_oe_ff <= 1'b0;
      rd_hit_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= rd_stb ? nxt_rd_data : 8'h00;
      rd_oe_ff <= rd_stb && nxt_rd_oe;
      rd_hit_ff <= rd_stb && (addr != `FSR_OFS_RSVD); // [RULE1]
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_data_oe = rd_oe_ff;
  assign rd_hit = rd_hit_ff;

  // Strobes to neighbouring controller registers
  assign main_rd = rd_stb && (addr == `FSR_OFS_MAIN); // [RULE1]
  assign data_rd = rd_stb && (addr == `FSR_OFS_DATA);
  assign data_wr = wr_stb && (addr == `FSR_OFS_DATA);
  assign tape_wr = wr_stb && (addr == `FSR_OFS_TAPE);
  assign rate_wr = wr_stb && (addr == `FSR_OFS_MAIN);
  assign cfg_wr = wr_stb && (addr == `FSR_OFS_DIN);

  a_legacy_float: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
    (rd_stb && mode == FSR_MODE_LEGACY && addr <= `FSR_OFS_STAT_B) |=> !rd_data_oe)
    else $error("status read drove bus in legacy mode");

  a_full_b_ones: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    (rd_stb && mode == FSR_MODE_FULL && addr == `FSR_OFS_STAT_B)
      |=> rd_data[7:6] == 2'b11 && rd_data_oe)
    else $error("full-status B top bits not one");

  a_sel_onehot: assert property (@(posedge clk) disable iff (!reset_n) // [RULE17]
    $onehot(drive_sel) && drive_sel[doc_ff.drive_sel])
    else $error("drive select not one-hot");

  a_step_latch: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
    step_rise |=> step_latch_ff)
    else $error("step latch missed edge");

  a_din_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RULE14]
    (din_rd && !write_gate_rise) |=> !write_gate_latch_ff)
    else $error("write gate latch not cleared");

  a_rdata_tog: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
    rdata_fall |=> rdata_tog_ff != $past(rdata_tog_ff))
    else $error("read data toggle did not flip");

  a_doc_write: assert property (@(posedge clk) disable iff (!reset_n) // [RULE16]
    (wr_stb && addr == `FSR_OFS_DOC) |=> (doc_ff == $past(wr_data)
      && motor_on == $past(wr_data[7:4])))
    else $error("output control write lost");

  a_srst_pulse: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
    (wr_stb && addr == `FSR_OFS_DOC && !wr_data[`FSR_DOC_SRST_BIT])
      |=> !ctrl_reset_n [*1])
    else $error("soft reset not asserted");

  a_full_pins_on: assert property (@(posedge clk) disable iff (!reset_n) // [RULE21]
    (mode == FSR_MODE_FULL) |-> (drq_oe && floppy_irq_oe))
    else $error("pins disabled in full-status mode");

  a_gate_off: assert property (@(posedge clk) disable iff (!reset_n) // [RULE20]
    (mode != FSR_MODE_FULL && !doc_ff.dma_gate) |-> (!drq_oe && !tc_core && dack_n_core))
    else $error("dma pins active while gated");

  a_srst_stretch: assert property (@(posedge clk) disable iff (!reset_n) // [RULE19]
    (wr_stb && addr == `FSR_OFS_DOC && !wr_data[`FSR_DOC_SRST_BIT])
      |=> !ctrl_reset_n [*8])
    else $error("soft reset pulse too short");

  a_write_gate_set: assert property (@(posedge clk) disable iff (!reset_n) // [RULE14]
    write_gate_rise |=> write_gate_latch_ff)
    else $error("write gate latch missed edge");

  a_rdata_latch: assert property (@(posedge clk) disable iff (!reset_n) // [RULE15]
    rdata_fall |=> rdata_latch_ff)
    else $error("read data latch missed edge");

  a_wdata_latch: assert property (@(posedge clk) disable iff (!reset_n) // [RULE15]
    wdata_fall |=> wdata_latch_ff)
    else $error("write data latch missed edge");

  a_rsvd_quiet: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    (rd_stb && addr == `FSR_OFS_RSVD) |=> (!rd_hit && !rd_data_oe && rd_data == 8'h00))
    else $error("reserved offset answered");

  a_full_b_motor: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
    (rd_stb && mode == FSR_MODE_FULL && addr == `FSR_OFS_STAT_B)
      |=> rd_data[1:0] == $past(doc_ff.motor_en[1:0]))
    else $error("full-status B motor bits wrong");
endmodule : fsr_regbank

// *** fsr_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH
`define FSR_OFS_STAT_A 3'h0
`define FSR_OFS_STAT_B 3'h1
`define FSR_OFS_DOC 3'h2
`define FSR_OFS_TAPE 3'h3
`define FSR_OFS_MAIN 3'h4
`define FSR_OFS_DATA 3'h5
`define FSR_OFS_RSVD 3'h6
`define FSR_OFS_DIN 3'h7
`define FSR_DOC_RESET 8'h00
`define FSR_DOC_DMA_BIT 3
`define FSR_DOC_SRST_BIT 2
`define FSR_SRST_MIN_NS 100
`define FSR_CLK_NS 8
`define FSR_SRST_CYC ((`FSR_SRST_MIN_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`endif

// *** fsr_pkg.sv ***
// Types shared by the floppy status and output register bank
package fsr_pkg;
  typedef enum logic [1:0] {
    FSR_MODE_LEGACY,
    FSR_MODE_FULL,
    FSR_MODE_COMPACT
  } fsr_mode_e;
  typedef struct packed {
    logic [3:0] motor_en;
    logic dma_gate;
    logic soft_reset_n;
    logic [1:0] drive_sel;
  } fsr_doc_s;
  typedef struct packed {
    logic direction_in;
    logic write_protect_n;
    logic index_pulse_n;
    logic head_side;
    logic track_zero_n;
    logic step;
    logic second_drive_present_n;
    logic read_data;
    logic write_data;
    logic write_gate;
  } fsr_drive_s;
endpackage : fsr_pkg

// *** fsr_host.sv ***
// Host processor model on the register byte bus
`timescale 1ns/10ps
module fsr_host (
  input wire logic clk,
  output logic [2:0] addr,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_data_oe,
  input wire logic rd_hit
);
  initial
  begin
    addr = 3'h6;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wr_data = 8'h00;
  end
  // Request held up to the taking edge
  task go(input logic w, input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    wr_stb = w;
    rd_stb = !w;
    addr = a;
    wr_data = v;
    @(posedge clk);
  endtask : go
  // Released data never shows the last value
  task idle();
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = ~wr_data;
  endtask : idle
  task wr(input logic [2:0] a, input logic [7:0] v);
    go(1'b1, a, v);
    idle();
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d, output logic oe, output logic hit);
    go(1'b0, a, 8'h00);
    idle();
    d = rd_data;
    oe = rd_data_oe;
    hit = rd_hit;
  endtask : rd
  // Two writes in consecutive cycles
  task wr_pair(input logic [2:0] a, input logic [7:0] v1, input logic [7:0] v2);
    go(1'b1, a, v1);
    #1;
    wr_data = v2;
    @(posedge clk);
    idle();
  endtask : wr_pair
endmodule : fsr_host

// *** fsr_regbank_bench.sv ***
// Self-checking bench for the floppy register bank
`timescale 1ns/10ps
`include "fsr_regs.svh"
module fsr_regbank_bench
  import fsr_pkg::*;
;
  logic clk;
  logic reset_n;
  fsr_mode_e mode;
  logic [2:0] addr;
  logic rd_stb;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic rd_data_oe;
  logic rd_hit;
  fsr_drive_s drv;
  logic irq_core;
  logic irq_oe;
  logic drq_oe;
  logic [3:0] motor_on;
  logic [3:0] drive_sel;
  logic ctrl_reset_n;
  int error_cnt;
  int cmp_count;
  int cyc;
  int lo_cnt;
  logic [7:0] d;
  logic oe;
  logic hit;
  fsr_host u_host (.clk(clk), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_data(rd_data), .rd_data_oe(rd_data_oe), .rd_hit(rd_hit));
  fsr_regbank u_dut (.clk(clk), .reset_n(reset_n), .mode(mode), .addr(addr),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .rd_hit(rd_hit), .drive_in(drv), .irq_core(irq_core),
    .drq_core(1'b0), .dack_n(1'b1), .tc(1'b0), .floppy_irq_out(), .floppy_irq_oe(irq_oe),
    .drq_out(), .drq_oe(drq_oe), .dack_n_core(), .tc_core(), .motor_on(motor_on),
    .drive_sel(drive_sel), .ctrl_reset_n(ctrl_reset_n), .main_rd(), .data_rd(),
    .data_wr(), .tape_wr(), .rate_wr(), .cfg_wr());
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task hw_rst(input fsr_mode_e m);
    reset_n = 1'b0;
    mode = m;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : hw_rst
  task pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : pause
  task t_full();
    logic [7:0] v [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
    chk("sel", {4'h0, drive_sel}, 8'h01);
    chk("srst", {7'h0, ctrl_reset_n}, 8'h00);
    chk("drqoe", {7'h0, drq_oe}, 8'h01);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'hc0);
    u_host.rd(3'h0, d, oe, hit);
    chk("a", d, 8'hcd);
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(3'h2, v[i]);
      chk("sel", {4'h0, drive_sel}, 8'h01 << i);
      chk("mot", {4'h0, motor_on}, 8'h01 << i);
    end
    u_host.wr(3'h2, 8'h2d);
    u_host.rd(3'h2, d, oe, hit);
    chk("doc", d, 8'h2d);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'he2);
  endtask : t_full
  task t_srst();
    lo_cnt = 0;
    u_host.wr_pair(3'h2, 8'h29, 8'h2d);
    chk("srst0", {7'h0, ctrl_reset_n}, 8'h00);
    pause(16);
    chk("lo", {7'h0, lo_cnt >= `FSR_SRST_CYC}, 8'h01);
    chk("srst", {7'h0, ctrl_reset_n}, 8'h01);
    u_host.rd(3'h2, d, oe, hit);
    chk("doc", d, 8'h2d);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'he2);
  endtask : t_srst
  task t_toggle();
    drv.read_data = 1'b1;
    pause(2);
    drv.read_data = 1'b0;
    pause(5);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'hea);
    drv.write_data = 1'b1;
    pause(2);
    drv.write_data = 1'b0;
    drv.write_gate = 1'b1;
    pause(5);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'hfe);
    drv.write_gate = 1'b0;
  endtask : t_toggle
  task t_compact();
    irq_core = 1'b0;
    hw_rst(FSR_MODE_COMPACT);
    chk("oe", {6'h0, drq_oe, irq_oe}, 8'h00);
    u_host.wr(3'h2, 8'h0d);
    chk("oe", {6'h0, drq_oe, irq_oe}, 8'h03);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'ha3);
    u_host.rd(3'h0, d, oe, hit);
    chk("a", d, 8'h12);
    drv.step = 1'b1;
    drv.write_gate = 1'b1;
    drv.read_data = 1'b1;
    drv.write_data = 1'b1;
    pause(2);
    drv = 10'h2c8;
    pause(5);
    u_host.rd(3'h0, d, oe, hit);
    chk("a", d, 8'h32);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'hbf);
    u_host.rd(3'h7, d, oe, hit);
    u_host.rd(3'h0, d, oe, hit);
    chk("a", d, 8'h12);
    u_host.rd(3'h1, d, oe, hit);
    chk("b", d, 8'ha3);
  endtask : t_compact
  task t_legacy();
    hw_rst(FSR_MODE_LEGACY);
    chk("irqoe", {7'h0, irq_oe}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      u_host.rd(i[2:0], d, oe, hit);
      chk("st", {6'h0, oe, hit}, 8'h01);
    end
    u_host.rd(3'h6, d, oe, hit);
    chk("rsvd", {d[5:0], oe, hit}, 8'h00);
    u_host.rd(3'h2, d, oe, hit);
    chk("doc", {d[6:0], oe}, 8'h01);
  endtask : t_legacy
  always @(posedge clk)
  begin
    cyc++;
    if (ctrl_reset_n === 1'b0)
      lo_cnt++;
    if (cyc > 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    lo_cnt = 0;
    irq_core = 1'b1;
    drv = 10'h2c8;
    hw_rst(FSR_MODE_FULL);
    t_full();
    t_srst();
    t_toggle();
    t_compact();
    t_legacy();
    close_out();
  end
endmodule : fsr_regbank_bench
